// [design/tws_pkg.sv]
// package: register map, field positions and state types of the two-wire slave
//
// Overview of operation
// - start is data falling while clock stays high.
// - a start sets the bus busy flag.
// - after start shift seven address bits msb first and compare with own address.
// - on address equality set address match flag and raise the interrupt request.
// - eighth bit after start is stored as the master direction flag.
// - on match, pull data low on the ninth clock as acknowledge.
// - direction flag one: software sets transmit select so the slave transmits.
// - direction flag zero: software clears transmit select so the slave receives.
// - data bytes are eight bits, msb first, after the address acknowledge.
// - as receiver drive the transmit acknowledge bit on the ninth clock.
// - as transmitter sample master's ninth clock level into receive acknowledge flag.
// - as transmitter on no acknowledge release data and wait for stop.
// - received bytes land in the data register; transmit shifts the written byte.
// - hold clock low after match until data register written or read.
// - one request for address match, byte completion and time out.
// - slave active only with mode field 110 and enable bit one.
// - incoming addresses are compared with the own address register value.
// - interrupt reaches the processor only while the interrupt enable is set.
// - receive acknowledge flag reads zero on master acknowledge, one otherwise.
`default_nettype none
package tws_pkg;
    // word byte addresses on the avalon slave
    localparam logic [3:0] CTRL_A_OFS = 4'h0;
    localparam logic [3:0] CTRL_B_OFS = 4'h4;
    localparam logic [3:0] DATA_OFS = 4'h8;
    localparam logic [3:0] ADDR_OFS = 4'hc;
    // serial_ctrl_reg_a fields
    localparam int MODE_LSB = 5;
    localparam logic [2:0] MODE_SLAVE = 3'h6;
    localparam int EN_BIT = 1;
    localparam int IRQEN_BIT = 0;
    // serial_ctrl_reg_b fields
    localparam int DONE_BIT = 7;
    localparam int MATCH_BIT = 6;
    localparam int BUSY_BIT = 5;
    localparam int TXSEL_BIT = 4;
    localparam int TX_ACK_CTRL_BIT = 3;
    localparam int DIR_BIT = 2;
    localparam int TOF_BIT = 1;
    localparam int RX_ACK_FLAG_BIT = 0;
    localparam logic [7:0] CTRL_B_RST = 8'h01;
    // own address sits in bits 7:1
    localparam int ADDR_LSB = 1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_DATA = 3'b010,
        ST_DACK = 3'b110,
        ST_WAIT = 3'b111
    } tws_state_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bus_req_t;
endpackage
`default_nettype wire

// [design/tws_slave.sv]
// two-wire slave transfer logic behind an avalon-mm register port
`default_nettype none
module tws_slave (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // avalon-mm register port
    input wire tws_pkg::bus_req_t bus_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    // two-wire bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // time-out event from outside, and the interrupt request
    input wire logic timeout_evt,
    output logic irq
);
    import tws_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detect
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // two flops per pin, then one more stage for edges
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] ctrl_a_r;
    logic [7:0] own_addr_r;
    logic [7:0] data_r;
    logic txsel_r;
    logic tx_ack_ctrl_r;
    logic done_r;
    logic match_r;
    logic busy_r;
    logic dir_r;
    logic tof_r;
    logic rx_ack_flag_r;
    logic hold_r;
    logic active;
    logic acc_r;
    logic wr_data;
    logic rd_data;
    logic wr_b;

    assign active = (ctrl_a_r[MODE_LSB +: 3] == MODE_SLAVE) && ctrl_a_r[EN_BIT];

    // one wait state: every access completes on the second cycle
    assign waitrequest = (bus_req.read | bus_req.write) & ~acc_r;
    assign wr_data = bus_req.write & acc_r & (bus_req.address == DATA_OFS);
    assign rd_data = bus_req.read & acc_r & (bus_req.address == DATA_OFS);
    assign wr_b = bus_req.write & acc_r & (bus_req.address == CTRL_B_OFS);

    // access phase toggle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= 1'b0;
        end else begin
            acc_r <= (bus_req.read | bus_req.write) & ~acc_r;
        end
    end

    // read data mux, unmapped reads return zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            readdata <= 32'h0;
        end else if (bus_req.read & ~acc_r) begin
            unique case (bus_req.address)
                CTRL_A_OFS: readdata <= {24'h0, ctrl_a_r};
                CTRL_B_OFS: readdata <= {24'h0, done_r, match_r, busy_r, txsel_r,
                                         tx_ack_ctrl_r, dir_r, tof_r, rx_ack_flag_r};
                DATA_OFS: readdata <= {24'h0, data_r};
                ADDR_OFS: readdata <= {24'h0, own_addr_r};
                default: readdata <= 32'h0;
            endcase
        end
    end

    // software-written configuration
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_a_r <= 8'h0;
            own_addr_r <= 8'h0;
            txsel_r <= CTRL_B_RST[TXSEL_BIT];
            tx_ack_ctrl_r <= CTRL_B_RST[TX_ACK_CTRL_BIT];
        end else if (bus_req.write & acc_r) begin
            if (bus_req.address == CTRL_A_OFS) begin
                ctrl_a_r <= bus_req.writedata[7:0];
            end
            if (bus_req.address == ADDR_OFS) begin
                own_addr_r <= bus_req.writedata[7:0];
            end
            if (bus_req.address == CTRL_B_OFS) begin
                txsel_r <= bus_req.writedata[TXSEL_BIT];
                tx_ack_ctrl_r <= bus_req.writedata[TX_ACK_CTRL_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engine
    tws_state_t state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_r;
    logic sda_low_r;
    logic addr_hit;
    logic ack_low;

    // shift_r[7:1] holds the calling address once eight bits are in
    assign addr_hit = addr_hit_w();

    // bit state machine; shifting on clock rise, driving after clock fall
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h0;
            bit_r <= 4'h0;
        end else if (!active || stop_det) begin
            state_r <= ST_IDLE;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: ;
                ST_ADDR: if (scl_rise) begin
                    shift_r <= {shift_r[6:0], sda_s};
                    bit_r <= bit_r + 4'h1;
                end else if (scl_fall && bit_r == 4'h8) begin
                    // shift_r[7:1] address, shift_r[0] direction
                    state_r <= (shift_r[7:1] == own_addr_r[ADDR_LSB +: 7]) ? ST_AACK : ST_IDLE;
                end
                ST_AACK: if (scl_fall && !hold_r) begin
                    state_r <= ST_DATA;
                    bit_r <= 4'h0;
                    shift_r <= data_r;
                end
                ST_DATA: if (scl_rise) begin
                    shift_r <= txsel_r ? {shift_r[6:0], 1'b0} : {shift_r[6:0], sda_s};
                    bit_r <= bit_r + 4'h1;
                end else if (scl_fall && bit_r == 4'h8) begin
                    state_r <= ST_DACK;
                end
                ST_DACK: if (txsel_r && scl_fall && rx_ack_flag_r) begin
                    state_r <= ST_WAIT;
                end else if (txsel_r && hold_r && wr_data) begin
                    // next transmit byte arrives while the clock is held low
                    state_r <= ST_DATA;
                    bit_r <= 4'h0;
                    shift_r <= bus_req.writedata[7:0];
                end else if (!txsel_r && scl_fall && !hold_r) begin
                    state_r <= ST_DATA;
                    bit_r <= 4'h0;
                    shift_r <= data_r;
                end
                ST_WAIT: ;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // clock stretch request after match, after each received byte and after each acknowledged sent byte
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_r <= 1'b0;
        end else if (!active || stop_det || start_det) begin
            hold_r <= 1'b0;
        end else if (state_r == ST_ADDR && scl_fall && bit_r == 4'h8
                     && shift_r[7:1] == own_addr_r[ADDR_LSB +: 7]) begin
            hold_r <= 1'b1;
        end else if (state_r == ST_DATA && scl_fall && bit_r == 4'h8 && !txsel_r) begin
            hold_r <= 1'b1;
        end else if (state_r == ST_DACK && scl_fall && txsel_r && !rx_ack_flag_r) begin
            hold_r <= 1'b1;
        end else if (wr_data || rd_data) begin
            hold_r <= 1'b0;
        end
    end

    // data line driver, pulls set only while the clock is low, released at any clock level when idle, waiting or inactive
    assign ack_low = (state_r == ST_AACK) || (state_r == ST_DACK && !txsel_r && !tx_ack_ctrl_r);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sda_low_r <= 1'b0;
        end else if (!active || state_r == ST_IDLE || state_r == ST_WAIT) begin
            sda_low_r <= 1'b0;
        end else if (!scl_s) begin
            if (state_r == ST_AACK) begin
                sda_low_r <= 1'b1;
            end else if (state_r == ST_DACK && txsel_r && wr_data) begin
                sda_low_r <= ~bus_req.writedata[7];
            end else if (state_r == ST_DACK) begin
                sda_low_r <= ack_low;
            end else if (state_r == ST_DATA && txsel_r) begin
                sda_low_r <= ~shift_r[7];
            end else begin
                sda_low_r <= 1'b0;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_low_r;
    assign scl_out = 1'b0;
    assign scl_oe = hold_r & ~scl_s;

    ////////////////////////////////////////////////////////////////////////
    // status flags; hardware set wins over software clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
        end else if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det || !active) begin
            busy_r <= 1'b0;
        end
    end

    // match and direction at the eighth bit
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            match_r <= 1'b0;
            dir_r <= 1'b0;
        end else if (state_r == ST_ADDR && scl_fall && bit_r == 4'h8) begin
            match_r <= (shift_r[7:1] == own_addr_r[ADDR_LSB +: 7]);
            dir_r <= shift_r[0];
        end else if (state_r == ST_DATA && scl_rise) begin
            match_r <= 1'b0;
        end
    end

    // receive buffer, acknowledge sample, completion and time-out flags
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_r <= 8'h0;
            rx_ack_flag_r <= CTRL_B_RST[RX_ACK_FLAG_BIT];
            done_r <= 1'b0;
            tof_r <= 1'b0;
        end else begin
            if (state_r == ST_DATA && scl_fall && bit_r == 4'h8) begin
                if (!txsel_r) begin
                    done_r <= 1'b1;
                    data_r <= shift_r;
                end
            end else if (state_r == ST_DACK && scl_fall && txsel_r) begin
                done_r <= 1'b1;
            end else if (state_r == ST_DATA && scl_rise) begin
                done_r <= 1'b0;
            end else if (wr_data) begin
                data_r <= bus_req.writedata[7:0];
            end
            if (state_r == ST_DACK && scl_rise && txsel_r) begin
                rx_ack_flag_r <= sda_s;
            end
            if (timeout_evt) begin
                tof_r <= 1'b1;
            end else if (wr_b && !bus_req.writedata[TOF_BIT]) begin
                tof_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // single request, gated by enable
    logic req_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            req_r <= 1'b0;
            irq <= 1'b0;
        end else begin
            req_r <= (state_r == ST_ADDR && scl_fall && bit_r == 4'h8 && addr_hit)
                   || (state_r == ST_DATA && scl_fall && bit_r == 4'h8 && !txsel_r)
                   || (state_r == ST_DACK && scl_fall && txsel_r)
                   || timeout_evt;
            irq <= (req_r | hold_r | tof_r) & ctrl_a_r[IRQEN_BIT];
        end
    end

    function automatic logic addr_hit_w();
        return shift_r[7:1] == own_addr_r[ADDR_LSB +: 7];
    endfunction

endmodule
`default_nettype wire

// [tb/test_tws_slave.sv]
// self-checking bench for the two-wire slave against a master model
`default_nettype none
module test_tws_slave;
    import tws_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MB = 1 << MATCH_BIT;
    localparam int BB = 1 << BUSY_BIT;
    localparam int DB = 1 << DIR_BIT;
    localparam int TB = 1 << TXSEL_BIT;
    localparam int KB = 1 << TX_ACK_CTRL_BIT;
    localparam int TO = 1 << TOF_BIT;
    localparam int RB = 1 << RX_ACK_FLAG_BIT;
    localparam int EN = 1 << EN_BIT;
    localparam int IE = 1 << IRQEN_BIT;
    localparam int CFG = (int'(MODE_SLAVE) << MODE_LSB) | EN | IE;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    bus_req_t bus_req = '0;
    logic timeout_evt = 1'b0;
    logic [31:0] readdata, rv;
    logic waitrequest, scl_oe, sda_oe, irq, scl_w, sda_w, m_scl, m_sda, ack;
    logic [6:0] own;
    logic [7:0] b;
    logic [7:0] q[$];
    int bad[2];
    int fails = 0;
    int samples_checked = 0;
    // wired-and bus with pull-ups
    assign scl_w = m_scl & ~scl_oe;
    assign sda_w = m_sda & ~sda_oe;
    tws_slave tws_slave_inst (.clock(clock), .sys_rst(sys_rst), .bus_req(bus_req),
        .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_w), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
        .timeout_evt(timeout_evt), .irq(irq));
    tws_master_model tws_master_model_inst (.scl_w(scl_w), .sda_w(sda_w), .scl_rel(m_scl),
        .sda_rel(m_sda));
    initial begin
        forever #2.5 clock = ~clock;
    end
    ////////////////////////////////////////
    // compare, bus access, status read and interrupt wait
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic [3:0] a, input logic wr, input logic [31:0] wd);
        int n;
        logic w;
        n = 0;
        @(posedge clock);
        bus_req <= '{a, !wr, wr, wd};
        // sample the answer settled, ahead of the edge that completes it
        do begin
            @(negedge clock);
            w = waitrequest;
            rv = readdata;
            @(posedge clock);
        end while (w !== 1'b0 && ++n < 99);
        check(w, 1'b0);
        bus_req <= '0;
    endtask
    task automatic st(input int m, input int e);
        acc(CTRL_B_OFS, 1'b0, 32'h0);
        check(rv & m, e);
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n++ < 9999) @(posedge clock);
        check(irq, lvl);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #150us;
        check(1'b0, 1'b1);
        report_and_stop();
    end
    ////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(2886));
        own = 7'($urandom);
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        st(32'hff, CTRL_B_RST);
        acc(4'h2, 1'b0, 32'h0);
        check(rv, 32'h0);
        acc(CTRL_A_OFS, 1'b1, CFG);
        acc(ADDR_OFS, 1'b1, 32'(own) << ADDR_LSB);
        acc(ADDR_OFS, 1'b0, 32'h0);
        check(rv[7:1], own);
        acc(CTRL_B_OFS, 1'b1, 32'h0);
        $display("test setup done");
        // foreign address: start seen, no answer
        tws_master_model_inst.start();
        st(BB, BB);
        tws_master_model_inst.wr_byte({own ^ 7'h01, 1'b0}, ack);
        check(ack, 1'b1);
        tws_master_model_inst.stop();
        st(BB | MB, 0);
        check(irq, 1'b0);
        $display("test foreign address done");
        // master writes two bytes, second one refused by the slave
        q = {8'($urandom), 8'($urandom)};
        fork
            begin
                tws_master_model_inst.start();
                tws_master_model_inst.wr_byte({own, 1'b0}, ack);
                check(ack, 1'b0);
                foreach (q[i]) begin
                    tws_master_model_inst.wr_byte(q[i], ack);
                    check(ack, i);
                end
                tws_master_model_inst.stop();
            end
            begin
                wait_irq(1'b1);
                st(MB | BB | DB, MB | BB);
                acc(DATA_OFS, 1'b0, 32'h0);
                foreach (q[i]) begin
                    wait_irq(1'b0);
                    wait_irq(1'b1);
                    acc(DATA_OFS, 1'b0, 32'h0);
                    check(rv, q[i]);
                    if (i == 0) acc(CTRL_B_OFS, 1'b1, KB);
                end
            end
        join
        st(BB, 0);
        $display("test slave receive done");
        // master reads two bytes, refusing the second
        q = {8'($urandom), 8'($urandom)};
        fork
            begin
                tws_master_model_inst.start();
                tws_master_model_inst.wr_byte({own, 1'b1}, ack);
                check(ack, 1'b0);
                foreach (q[i]) begin
                    tws_master_model_inst.rd_byte(i == 1, b);
                    check(b, q[i]);
                end
                tws_master_model_inst.stop();
            end
            begin
                wait_irq(1'b1);
                st(MB | DB, MB | DB);
                acc(CTRL_B_OFS, 1'b1, TB);
                foreach (q[i]) begin
                    acc(DATA_OFS, 1'b1, q[i]);
                    wait_irq(1'b0);
                    wait_irq(1'b1);
                    st(RB, i == 1 ? RB : 0);
                end
                check(sda_oe, 1'b0);
                acc(DATA_OFS, 1'b0, 32'h0);
            end
        join
        $display("test slave transmit done");
        // time-out event with the interrupt enabled, then disabled
        for (int e = 1; e >= 0; e--) begin
            acc(CTRL_A_OFS, 1'b1, e ? CFG : CFG ^ IE);
            timeout_evt <= 1'b1;
            @(posedge clock);
            timeout_evt <= 1'b0;
            repeat (8) @(posedge clock);
            check(irq, e);
            st(TO, TO);
            acc(CTRL_B_OFS, 1'b1, 32'h0);
            st(TO, 0);
        end
        $display("test time-out done");
        // slave stays deaf unless mode and enable are both right
        bad = '{CFG ^ EN, CFG ^ (3 << MODE_LSB)};
        foreach (bad[i]) begin
            acc(CTRL_A_OFS, 1'b1, bad[i]);
            tws_master_model_inst.start();
            tws_master_model_inst.wr_byte({own, 1'b0}, ack);
            check(ack, 1'b1);
            tws_master_model_inst.stop();
        end
        $display("test disabled port done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [tb/tws_master_model.sv]
// two-wire bus master model with open-drain releases and stretch-aware clocking
`default_nettype none
module tws_master_model (
    // wire levels seen on the bus
    input wire logic scl_w,
    input wire logic sda_w,
    // releases, high lets the pull-up win
    output logic scl_rel,
    output logic sda_rel
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    ////////////////////////////////////////
    // one bit of 48 ns: set data while clock low, sample at clock high
    task automatic bit_x(input logic b, output logic s);
        sda_rel = b;
        #12 scl_rel = 1'b1;
        wait (scl_w === 1'b1);
        #12 s = sda_w;
        #12 scl_rel = 1'b0;
        #12;
    endtask
    // only this side ever makes a start
    task automatic start();
        #24 sda_rel = 1'b0;
        #24 scl_rel = 1'b0;
        #12;
    endtask
    // stop also ends any unanswered call
    task automatic stop();
        sda_rel = 1'b0;
        #12 scl_rel = 1'b1;
        wait (scl_w === 1'b1);
        #24 sda_rel = 1'b1;
        #24;
    endtask
    // eight bits msb first, then the ninth-clock answer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, ack);
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, s);
    endtask
endmodule
`default_nettype wire

// [tb/tws_slave_assertions.sv]
// concurrent checks on the two-wire slave ports
`default_nettype none
module tws_slave_assertions
    import tws_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire tws_pkg::bus_req_t bus_req,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // bus pins and events
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic timeout_evt,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic req;
    assign req = bus_req.read | bus_req.write;
    ////////////////////////////////////////
    // register port handshake
    a_wait_first: assert property ($rose(req) |-> waitrequest)
        else $error("access answered without a wait state");
    a_one_wait: assert property (req && waitrequest |=> req && !waitrequest)
        else $error("access not answered after one wait state");
    a_read_holds: assert property ($changed(readdata) |-> $past(bus_req.read && waitrequest))
        else $error("read data moved without a read");
    a_upper_zero: assert property (bus_req.read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // pins only ever pull low, and start or change a pull only while the clock is low
    a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin driven high");
    a_data_on_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data pull changed while clock high");
    a_hold_on_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
        else $error("clock hold began while clock high");
    a_data_release: assert property (bus_req.address == DATA_OFS && req && !waitrequest
        |-> ##[1:4] !scl_oe)
        else $error("data access did not release clock hold");
    c_hold: cover property ($rose(scl_oe));
    c_irq: cover property ($rose(irq));
    c_timeout: cover property (timeout_evt ##[1:3] irq);
endmodule
bind tws_slave tws_slave_assertions tws_slave_assertions_inst (.clock(clock), .sys_rst(sys_rst),
    .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .timeout_evt(timeout_evt), .irq(irq));
`default_nettype wire
